// File: rtl/arri_defs.svh
// Offsets, fields, reset values and timing counts of the rate register bank.
// Included by the design file only.
`ifndef ARRI_DEFS_SVH
`define ARRI_DEFS_SVH

// ========
// Register offsets
`define ARRI_OFS_ID        8'h00
`define ARRI_OFS_XL        8'h02
`define ARRI_OFS_XH        8'h03
`define ARRI_OFS_YL        8'h04
`define ARRI_OFS_YH        8'h05
`define ARRI_OFS_ZL        8'h06
`define ARRI_OFS_ZH        8'h07
`define ARRI_OFS_EVSTAT    8'h0a
`define ARRI_OFS_QSTAT     8'h0e
`define ARRI_OFS_RANGE     8'h0f
`define ARRI_OFS_BW        8'h10
`define ARRI_OFS_PWR       8'h11
`define ARRI_OFS_RESTART   8'h14
`define ARRI_OFS_EVEN      8'h15
`define ARRI_OFS_PINCONF   8'h16
`define ARRI_OFS_PINMAP    8'h18
`define ARRI_OFS_WMEN      8'h1e
`define ARRI_OFS_EXTSYNC   8'h34
`define ARRI_OFS_SELFTEST  8'h3c
`define ARRI_OFS_QTHR      8'h3d
`define ARRI_OFS_QCFG      8'h3e
`define ARRI_OFS_QDATA     8'h3f
`define ARRI_OFS_IRQSTAT   8'h40
`define ARRI_OFS_IRQMASK   8'h41

// ========
// Reset values and codes
`define ARRI_RST_RANGE     8'h00
`define ARRI_RST_BW        8'h80
`define ARRI_BW_FIXED      8'h80
`define ARRI_RST_PWR       8'h00
`define ARRI_RST_EVEN      8'h00
`define ARRI_RST_PINCONF   8'h0f
`define ARRI_RST_PINMAP    8'h00
`define ARRI_RST_ZERO      8'h00
`define ARRI_RESTART_KEY   8'hb6
`define ARRI_PWR_NORMAL    8'h00
`define ARRI_PWR_SUSPEND   8'h80
`define ARRI_PWR_DEEP      8'h20

// ========
// Field positions
`define ARRI_BIT_DRDY      7
`define ARRI_BIT_QINT      4
`define ARRI_BIT_OVF       7

// ========
// Timing counts
`define ARRI_CLK_PS        5000
`define ARRI_DRDY_MIN_US   280
`define ARRI_DRDY_CYC      ((`ARRI_DRDY_MIN_US * 1000000 + `ARRI_CLK_PS - 1) / `ARRI_CLK_PS)
`define ARRI_RESTART_MS    30
`define ARRI_RESTART_CYC   (`ARRI_RESTART_MS * 1000000 / (`ARRI_CLK_PS / 1000))

`endif

// File: rtl/arri_pkg.sv
// Types shared by the rate register bank.
// Assumes nothing of its surroundings.
package arri_pkg;

    typedef enum logic [1:0] {
        ARRI_ST_IDLE    = 2'b00,
        ARRI_ST_ACK     = 2'b01
    } arri_bus_state_t;

endpackage

// File: rtl/arri_regbank.sv
// Register bank of the angular-rate unit behind a classic Wishbone slave.
// Assumes core samples arrive with a one-cycle strobe.
`timescale 1ns/100ps
`include "arri_defs.svh"

module arri_regbank #(
    parameter logic [7:0]  RATE_UNIT_ID_VALUE = 8'h5a,  // Value is arbitrary.
    parameter int unsigned DRDY_CYCLES        = `ARRI_DRDY_CYC,
    parameter int unsigned RESTART_CYCLES     = `ARRI_RESTART_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sample_valid_i,
    input  wire logic [15:0] sample_x_i,
    input  wire logic [15:0] sample_y_i,
    input  wire logic [15:0] sample_z_i,
    input  wire logic        queue_event_i,
    input  wire logic        queue_push_i,
    input  wire logic        queue_pop_i,
    input  wire logic [7:0]  queue_data_i,
    output logic      [7:0]  range_code_o,
    output logic      [7:0]  filter_code_o,
    output logic      [7:0]  power_state_code_o,
    output logic      [7:0]  self_test_o,
    output logic             restart_pending_o,
    output logic             irq_o
);

    // ========
    // Bus slave state
    arri_pkg::arri_bus_state_t bus_state;
    arri_pkg::arri_bus_state_t next_bus_state;
    logic [31:0]               rd_data;
    logic [31:0]               next_rd_data;

    wire logic req      = wb_cyc_i && wb_stb_i && (bus_state == arri_pkg::ARRI_ST_IDLE);
    wire logic wr_take  = req && wb_we_i && wb_sel_i[0];
    wire logic rd_take  = req && !wb_we_i;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ========
    // Register state
    logic [15:0] rate_x, rate_y, rate_z;
    logic [7:0]  hold_xh, hold_yh, hold_zh;
    logic [2:0]  lock;
    logic [7:0]  range_code, filter_code, power_state_code, event_en;
    logic [7:0]  pin_conf, pin_map, wm_en, ext_sync, self_test, q_thr, q_cfg;
    logic        drdy, qint;
    logic [31:0] drdy_cnt;
    logic [6:0]  q_fill;
    logic        q_ovf;
    logic [1:0]  irq_stat, irq_mask;
    logic        restart_pend;
    logic [31:0] restart_cnt;

    logic [15:0] next_rate_x, next_rate_y, next_rate_z;
    logic [7:0]  next_hold_xh, next_hold_yh, next_hold_zh;
    logic [2:0]  next_lock;
    logic [7:0]  next_range_code, next_filter_code, next_power_state_code, next_event_en;
    logic [7:0]  next_pin_conf, next_pin_map, next_wm_en, next_ext_sync, next_self_test;
    logic [7:0]  next_q_thr, next_q_cfg;
    logic        next_drdy, next_qint;
    logic [31:0] next_drdy_cnt;
    logic [6:0]  next_q_fill;
    logic        next_q_ovf;
    logic [1:0]  next_irq_stat, next_irq_mask;
    logic        next_restart_pend;
    logic [31:0] next_restart_cnt;

    // Power moves between the two suspend codes are refused.
    function automatic logic pwr_ok(input logic [7:0] cur, input logic [7:0] req_code);
        pwr_ok = (req_code == `ARRI_PWR_NORMAL || req_code == `ARRI_PWR_SUSPEND ||
                  req_code == `ARRI_PWR_DEEP) &&
                 !(cur == `ARRI_PWR_SUSPEND && req_code == `ARRI_PWR_DEEP) &&
                 !(cur == `ARRI_PWR_DEEP && req_code == `ARRI_PWR_SUSPEND);
    endfunction

    // ========
    // Next-state logic
    always_comb begin
        next_bus_state        = arri_pkg::ARRI_ST_IDLE;
        next_rd_data          = rd_data;

        next_rate_x           = rate_x;
        next_rate_y           = rate_y;
        next_rate_z           = rate_z;
        next_hold_xh          = hold_xh;
        next_hold_yh          = hold_yh;
        next_hold_zh          = hold_zh;
        next_lock             = lock;

        next_range_code       = range_code;
        next_filter_code      = filter_code;
        next_power_state_code = power_state_code;
        next_event_en         = event_en;
        next_pin_conf         = pin_conf;
        next_pin_map          = pin_map;
        next_wm_en            = wm_en;
        next_ext_sync         = ext_sync;
        next_self_test        = self_test;
        next_q_thr            = q_thr;
        next_q_cfg            = q_cfg;

        next_drdy             = drdy;
        next_qint             = qint | queue_event_i;
        next_drdy_cnt         = drdy_cnt;
        next_q_fill           = q_fill;
        next_q_ovf            = q_ovf;

        next_irq_stat         = irq_stat;
        next_irq_mask         = irq_mask;
        next_restart_pend     = restart_pend;
        next_restart_cnt      = restart_cnt;

        if (req) begin
            next_bus_state = arri_pkg::ARRI_ST_ACK;
        end

        // Ready flag lives a fixed time, then drops by itself.
        if (drdy) begin
            if (drdy_cnt == 32'h1) begin
                next_drdy = 1'b0;
            end
            next_drdy_cnt = drdy_cnt - 32'h1;
        end

        // New sample: high bytes under lock keep their frozen copy.
        if (sample_valid_i) begin
            next_rate_x   = sample_x_i;
            next_rate_y   = sample_y_i;
            next_rate_z   = sample_z_i;
            next_drdy     = 1'b1;
            next_drdy_cnt = DRDY_CYCLES;
        end

        // Queue fill level follows the core; overflow is sticky.
        if (queue_push_i && !queue_pop_i) begin
            if (q_fill == 7'h7f) begin
                next_q_ovf = 1'b1;
            end else begin
                next_q_fill = q_fill + 7'h01;
            end
        end else if (queue_pop_i && !queue_push_i && q_fill != 7'h00) begin
            next_q_fill = q_fill - 7'h01;
        end

        // Low-byte read takes a snapshot of the high byte.
        if (rd_take) begin
            case (wb_adr_i)
                `ARRI_OFS_XL: begin
                    next_hold_xh = rate_x[15:8];
                    next_lock[0] = 1'b1;
                end
                `ARRI_OFS_YL: begin
                    next_hold_yh = rate_y[15:8];
                    next_lock[1] = 1'b1;
                end
                `ARRI_OFS_ZL: begin
                    next_hold_zh = rate_z[15:8];
                    next_lock[2] = 1'b1;
                end
                `ARRI_OFS_XH: next_lock[0] = 1'b0;
                `ARRI_OFS_YH: next_lock[1] = 1'b0;
                `ARRI_OFS_ZH: next_lock[2] = 1'b0;
                default: begin
                end
            endcase
        end

        if (wr_take) begin
            case (wb_adr_i)
                `ARRI_OFS_RANGE:    next_range_code  = wb_dat_i[7:0];
                `ARRI_OFS_BW:       next_filter_code = wb_dat_i[7:0] | `ARRI_BW_FIXED;
                `ARRI_OFS_PWR: begin
                    if (pwr_ok(power_state_code, wb_dat_i[7:0])) begin
                        next_power_state_code = wb_dat_i[7:0];
                    end
                end
                `ARRI_OFS_RESTART: begin
                    if (wb_dat_i[7:0] == `ARRI_RESTART_KEY) begin
                        next_restart_pend = 1'b1;
                        next_restart_cnt  = RESTART_CYCLES;
                    end
                end
                `ARRI_OFS_EVEN:     next_event_en  = wb_dat_i[7:0] & 8'hc0;
                `ARRI_OFS_PINCONF:  next_pin_conf  = wb_dat_i[7:0] & 8'h0f;
                `ARRI_OFS_PINMAP:   next_pin_map   = wb_dat_i[7:0] & 8'ha5;
                `ARRI_OFS_WMEN:     next_wm_en     = wb_dat_i[7:0];
                `ARRI_OFS_EXTSYNC:  next_ext_sync  = wb_dat_i[7:0] & 8'h30;
                `ARRI_OFS_SELFTEST: next_self_test = wb_dat_i[7:0] & 8'h01;
                `ARRI_OFS_QTHR:     next_q_thr     = wb_dat_i[7:0];
                `ARRI_OFS_QCFG: begin
                    next_q_cfg  = wb_dat_i[7:0];
                    next_q_fill = 7'h00;
                    next_q_ovf  = queue_push_i && !queue_pop_i && q_fill == 7'h7f;
                end
                `ARRI_OFS_IRQMASK:  next_irq_mask = wb_dat_i[1:0];
                default: begin
                end
            endcase
        end

        // Sticky interrupt bits: a new event wins over a same-cycle clear.
        if (wr_take && hit(wb_adr_i, `ARRI_OFS_IRQSTAT)) begin
            next_irq_stat = irq_stat & ~wb_dat_i[1:0];
        end
        next_irq_stat = next_irq_stat | {queue_event_i, sample_valid_i};

        // Restart restores configuration, except the interrupt mask, once the delay runs out.
        if (restart_pend) begin
            next_restart_cnt = restart_cnt - 32'h1;
            if (restart_cnt == 32'h1) begin
                next_restart_pend     = 1'b0;
                next_range_code       = `ARRI_RST_RANGE;
                next_filter_code      = `ARRI_RST_BW;
                next_power_state_code = `ARRI_RST_PWR;
                next_event_en         = `ARRI_RST_EVEN;
                next_pin_conf         = `ARRI_RST_PINCONF;
                next_pin_map          = `ARRI_RST_PINMAP;
                next_wm_en            = `ARRI_RST_ZERO;
                next_ext_sync         = `ARRI_RST_ZERO;
                next_self_test        = `ARRI_RST_ZERO;
                next_q_thr            = `ARRI_RST_ZERO;
                next_q_cfg            = `ARRI_RST_ZERO;
            end
        end

        // Read data mux.
        if (rd_take) begin
            next_rd_data = 32'h0;
            case (wb_adr_i)
                `ARRI_OFS_ID:       next_rd_data[7:0] = RATE_UNIT_ID_VALUE;
                `ARRI_OFS_XL:       next_rd_data[7:0] = rate_x[7:0];
                `ARRI_OFS_XH:       next_rd_data[7:0] = lock[0] ? hold_xh : rate_x[15:8];
                `ARRI_OFS_YL:       next_rd_data[7:0] = rate_y[7:0];
                `ARRI_OFS_YH:       next_rd_data[7:0] = lock[1] ? hold_yh : rate_y[15:8];
                `ARRI_OFS_ZL:       next_rd_data[7:0] = rate_z[7:0];
                `ARRI_OFS_ZH:       next_rd_data[7:0] = lock[2] ? hold_zh : rate_z[15:8];
                `ARRI_OFS_EVSTAT: begin
                    next_rd_data[`ARRI_BIT_DRDY] = drdy;
                    next_rd_data[`ARRI_BIT_QINT] = qint;
                end
                `ARRI_OFS_QSTAT:    next_rd_data[7:0] = {q_ovf, q_fill};
                `ARRI_OFS_RANGE:    next_rd_data[7:0] = range_code;
                `ARRI_OFS_BW:       next_rd_data[7:0] = filter_code;
                `ARRI_OFS_PWR:      next_rd_data[7:0] = power_state_code;
                `ARRI_OFS_EVEN:     next_rd_data[7:0] = event_en;
                `ARRI_OFS_PINCONF:  next_rd_data[7:0] = pin_conf;
                `ARRI_OFS_PINMAP:   next_rd_data[7:0] = pin_map;
                `ARRI_OFS_WMEN:     next_rd_data[7:0] = wm_en;
                `ARRI_OFS_EXTSYNC:  next_rd_data[7:0] = ext_sync;
                `ARRI_OFS_SELFTEST: next_rd_data[7:0] = {4'h0, 1'b1, 1'b0, 1'b1, self_test[0]};
                `ARRI_OFS_QTHR:     next_rd_data[7:0] = q_thr;
                `ARRI_OFS_QCFG:     next_rd_data[7:0] = q_cfg;
                `ARRI_OFS_QDATA:    next_rd_data[7:0] = queue_data_i;
                `ARRI_OFS_IRQSTAT:  next_rd_data[1:0] = irq_stat;
                `ARRI_OFS_IRQMASK:  next_rd_data[1:0] = irq_mask;
                default:            next_rd_data      = 32'h0;
            endcase
        end
    end

    // ========
    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state        <= arri_pkg::ARRI_ST_IDLE;
            rd_data          <= 32'h0;

            rate_x           <= 16'h0000;
            rate_y           <= 16'h0000;
            rate_z           <= 16'h0000;
            hold_xh          <= 8'h00;
            hold_yh          <= 8'h00;
            hold_zh          <= 8'h00;
            lock             <= 3'h0;

            range_code       <= `ARRI_RST_RANGE;
            filter_code      <= `ARRI_RST_BW;
            power_state_code <= `ARRI_RST_PWR;
            event_en         <= `ARRI_RST_EVEN;
            pin_conf         <= `ARRI_RST_PINCONF;
            pin_map          <= `ARRI_RST_PINMAP;
            wm_en            <= `ARRI_RST_ZERO;
            ext_sync         <= `ARRI_RST_ZERO;
            self_test        <= `ARRI_RST_ZERO;
            q_thr            <= `ARRI_RST_ZERO;
            q_cfg            <= `ARRI_RST_ZERO;

            drdy             <= 1'b0;
            qint             <= 1'b0;
            drdy_cnt         <= 32'h0;
            q_fill           <= 7'h00;
            q_ovf            <= 1'b0;

            irq_stat         <= 2'h0;
            irq_mask         <= 2'h0;
            restart_pend     <= 1'b0;
            restart_cnt      <= 32'h0;
        end else if (ce_i) begin
            bus_state        <= next_bus_state;
            rd_data          <= next_rd_data;

            rate_x           <= next_rate_x;
            rate_y           <= next_rate_y;
            rate_z           <= next_rate_z;
            hold_xh          <= next_hold_xh;
            hold_yh          <= next_hold_yh;
            hold_zh          <= next_hold_zh;
            lock             <= next_lock;

            range_code       <= next_range_code;
            filter_code      <= next_filter_code;
            power_state_code <= next_power_state_code;
            event_en         <= next_event_en;
            pin_conf         <= next_pin_conf;
            pin_map          <= next_pin_map;
            wm_en            <= next_wm_en;
            ext_sync         <= next_ext_sync;
            self_test        <= next_self_test;
            q_thr            <= next_q_thr;
            q_cfg            <= next_q_cfg;

            drdy             <= next_drdy;
            qint             <= next_qint;
            drdy_cnt         <= next_drdy_cnt;
            q_fill           <= next_q_fill;
            q_ovf            <= next_q_ovf;

            irq_stat         <= next_irq_stat;
            irq_mask         <= next_irq_mask;
            restart_pend     <= next_restart_pend;
            restart_cnt      <= next_restart_cnt;
        end
    end

    // ========
    // Outputs
    assign wb_ack_o           = (bus_state == arri_pkg::ARRI_ST_ACK);
    assign wb_dat_o           = rd_data;
    assign range_code_o       = range_code;
    assign filter_code_o      = filter_code;
    assign power_state_code_o = power_state_code;
    assign self_test_o        = self_test;
    assign restart_pending_o  = restart_pend;
    assign irq_o              = |(irq_stat & irq_mask);

endmodule

// File: bench/arri_regbank_properties.sv
// Port checker of the rate register bank.
// Assumes a bind to arri_regbank, one clock.
`timescale 1ns/100ps
module arri_props #(
    parameter logic [7:0]  RATE_UNIT_ID_VALUE = 8'h5a,
    parameter int unsigned RESTART_CYCLES     = 50
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  range_code_o,
    input wire logic [7:0]  filter_code_o,
    input wire logic [7:0]  power_state_code_o,
    input wire logic        restart_pending_o
);
    // ========
    // Request decode
    localparam int RC_MAX = RESTART_CYCLES + 3;
    logic tk, rd, wr, key;
    assign tk = wb_cyc_i & wb_stb_i & ce_i & ~wb_ack_o;
    assign rd = tk & ~wb_we_i;
    assign wr = tk & wb_we_i & wb_sel_i[0];
    assign key = wr && wb_adr_i == 8'h14 && wb_dat_i[7:0] == 8'hb6;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========
    // Properties
    property p_rd_ack; rd |=> wb_ack_o && wb_dat_o[31:8] == 24'h0; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("bad read");
    property p_id; rd && wb_adr_i == 8'h00 |=> wb_dat_o[7:0] == RATE_UNIT_ID_VALUE; endproperty
    a_id: assert property (p_id) else $error("bad id");
    property p_resv; rd && wb_adr_i inside {8'h01, 8'h08, 8'h0b, 8'h12, 8'h17} |=> wb_dat_o == 32'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved nonzero");
    property p_stat; rd && wb_adr_i == 8'h0a |=> (wb_dat_o[7:0] & 8'h6f) == 8'h00; endproperty
    a_stat: assert property (p_stat) else $error("status bits");
    property p_range_wr; wr && wb_adr_i == 8'h0f |=> range_code_o == $past(wb_dat_i[7:0]); endproperty
    a_range_wr: assert property (p_range_wr) else $error("range write lost");
    property p_range_hold;
        $changed(range_code_o) |-> $past(rst_i) || $past(wr && wb_adr_i == 8'h0f)
            || $past(restart_pending_o) || $past(restart_pending_o, 2);
    endproperty
    a_range_hold: assert property (p_range_hold) else $error("range drift");
    property p_pwr; power_state_code_o == 8'h80 |=> power_state_code_o != 8'h20; endproperty
    a_pwr: assert property (p_pwr) else $error("suspend to deep");
    property p_rst_go; key |=> restart_pending_o [*8]; endproperty
    a_rst_go: assert property (p_rst_go) else $error("restart not started");
    property p_rst_only; $rose(restart_pending_o) |-> $past(key); endproperty
    a_rst_only: assert property (p_rst_only) else $error("restart without key");
    property p_rst_end; $rose(restart_pending_o) |-> ##[1:RC_MAX] !restart_pending_o; endproperty
    a_rst_end: assert property (p_rst_end) else $error("restart hung");
    property p_rst_cfg;
        $fell(restart_pending_o) |-> ##[0:1] range_code_o == 8'h00 && filter_code_o == 8'h80
            && power_state_code_o == 8'h00;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("config not restored");
endmodule

bind arri_regbank arri_props #(.RATE_UNIT_ID_VALUE(RATE_UNIT_ID_VALUE), .RESTART_CYCLES(RESTART_CYCLES)) u_props (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .range_code_o, .filter_code_o, .power_state_code_o, .restart_pending_o);

// File: bench/arri_host.sv
// Wishbone host model of the rate register bank.
// Assumes the same clock as the bank; callers enter just after a rising edge.
`timescale 1ns/100ps
module arri_host (
    input  wire logic        clk_i,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_cyc_o = 1'b0,
    output logic             wb_stb_o = 1'b0,
    output logic             wb_we_o = 1'b0,
    output logic      [7:0]  wb_adr_o = 8'h0,
    output logic      [3:0]  wb_sel_o = 4'h0,
    output logic      [31:0] wb_dat_o = 32'h0
);
    logic [7:0] mode = 8'h00;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output bit ok);
        ok = 1'b0;
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= s;
        wb_dat_o <= d;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_i);
            ok = (wb_ack_i === 1'b1);
        end
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        @(posedge clk_i);
    endtask
    // A change between the two suspend states always passes through normal.
    task automatic set_power(input logic [7:0] c, output bit ok);
        logic [31:0] q;
        ok = 1'b1;
        if (mode != 8'h00 && c != 8'h00) xfer(1'b1, 8'h11, 32'h0, 4'h1, q, ok);
        if (ok) xfer(1'b1, 8'h11, {24'h0, c}, 4'h1, q, ok);
        mode = c;
    endtask
    task automatic restart(output bit ok);
        logic [31:0] q;
        xfer(1'b1, 8'h14, 32'hb6, 4'h1, q, ok);
        mode = 8'h00;
    endtask
endmodule

// File: bench/tb_angular_rate_register_interface.sv
// Self-checking bench of the rate register bank.
// Assumes arri_regbank with short ready and restart counts.
`timescale 1ns/100ps
module tb_angular_rate_register_interface;
    localparam int DRDY = 20;
    localparam int RSTC = 50;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sv = 1'b0, qev = 1'b0, qpush = 1'b0, qpop = 1'b0;
    logic [15:0] sx = 16'h0, sy = 16'h0, sz = 16'h0;
    logic        cyc, stb, we, ack, pend, irq;
    logic [7:0]  adr, rng, flt, pwr, stst;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    int          fail_count = 0;
    int          checks_done = 0;
    always #2.5 clk_i = ~clk_i;
    arri_host host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
    arri_regbank #(.DRDY_CYCLES(DRDY), .RESTART_CYCLES(RSTC)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .sample_valid_i(sv), .sample_x_i(sx), .sample_y_i(sy),
        .sample_z_i(sz), .queue_event_i(qev), .queue_push_i(qpush), .queue_pop_i(qpop),
        .queue_data_i(8'h3c), .range_code_o(rng), .filter_code_o(flt), .power_state_code_o(pwr),
        .self_test_o(stst), .restart_pending_o(pend), .irq_o(irq));
    // ========
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ok_or_stop(input bit ok);
        if (!ok) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bit ok;
        host.xfer(1'b1, a, {24'h0, d}, 4'h1, q, ok);
        ok_or_stop(ok);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [31:0] q;
        bit ok;
        host.xfer(1'b0, a, 32'h0, 4'h1, q, ok);
        ok_or_stop(ok);
        chk("upper lanes", 32'h0, {8'h0, q[31:8]});
        d = q[7:0];
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, d});
    endtask
    task automatic sample(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        sx <= x;
        sy <= y;
        sz <= z;
        sv <= 1'b1;
        @(posedge clk_i);
        sv <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic queue(input logic push, input int n);
        qpush <= push;
        qpop <= !push;
        repeat (n) @(posedge clk_i);
        qpush <= 1'b0;
        qpop <= 1'b0;
        @(posedge clk_i);
    endtask
    // ========
    // Scenarios
    task automatic t_regs();
        logic [7:0] a [14] = '{8'h0f, 8'h10, 8'h11, 8'h15, 8'h16, 8'h18, 8'h1e, 8'h34, 8'h3d, 8'h3e, 8'h41, 8'h00,
                               8'h3c, 8'h3f};
        logic [7:0] v [14] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a,
                               8'h0a, 8'h3c};
        logic [7:0] z [5] = '{8'h01, 8'h08, 8'h0b, 8'h13, 8'h50};
        logic [31:0] q;
        bit ok;
        wr(8'h00, 8'h33);
        foreach (a[i]) rdchk(a[i], v[i]);
        foreach (z[i]) wr(z[i], 8'hff);
        foreach (z[i]) rdchk(z[i], 8'h00);
        for (int c = 0; c < 5; c++) begin
            wr(8'h0f, 8'(c));
            chk("range", c, {24'h0, rng});
        end
        host.xfer(1'b1, 8'h0f, 32'h2, 4'he, q, ok);
        rdchk(8'h0f, 8'h04);
    endtask
    task automatic t_rates();
        logic [7:0] lo, hi;
        wr(8'h40, 8'h03);
        wr(8'h41, 8'h01);
        chk("irq idle", 32'h0, {31'h0, irq});
        sample(16'h8001, 16'h7fff, 16'h0000);
        rdchk(8'h0a, 8'h80);
        chk("irq set", 32'h1, {31'h0, irq});
        rd(8'h04, lo);
        rd(8'h05, hi);
        chk("y", 32'h7fff, {16'h0, hi, lo});
        rd(8'h06, lo);
        rd(8'h07, hi);
        chk("z", 32'h0, {16'h0, hi, lo});
        rd(8'h02, lo);
        sample(16'h1234, 16'h0, 16'h0);
        rd(8'h03, hi);
        chk("x", 32'h8001, {16'h0, hi, lo});
        rd(8'h02, lo);
        rd(8'h03, hi);
        chk("x sum", 32'h1234, 32'(hi) * 256 + 32'(lo));
        repeat (DRDY - 12) @(posedge clk_i);
        rdchk(8'h0a, 8'h80);
        repeat (12) @(posedge clk_i);
        rdchk(8'h0a, 8'h00);
        wr(8'h41, 8'h00);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h41, 8'h01);
        wr(8'h40, 8'h01);
        chk("irq clear", 32'h0, {31'h0, irq});
    endtask
    task automatic t_queue();
        qev <= 1'b1;
        @(posedge clk_i);
        qev <= 1'b0;
        @(posedge clk_i);
        rdchk(8'h0a, 8'h10);
        queue(1'b1, 3);
        queue(1'b0, 1);
        rdchk(8'h0e, 8'h02);
        queue(1'b0, 2);
        rdchk(8'h0e, 8'h00);
        queue(1'b1, 130);
        rdchk(8'h0e, 8'hff);
        wr(8'h3e, 8'h00);
        rdchk(8'h0e, 8'h00);
    endtask
    task automatic t_power();
        logic [7:0] c [7] = '{8'h80, 8'h20, 8'h00, 8'h20, 8'h80, 8'h55, 8'h00};
        logic [7:0] e [7] = '{8'h80, 8'h80, 8'h00, 8'h20, 8'h20, 8'h20, 8'h00};
        foreach (c[i]) begin
            wr(8'h11, c[i]);
            chk("power", {24'h0, e[i]}, {24'h0, pwr});
        end
    endtask
    task automatic t_restart();
        int n;
        bit ok;
        wr(8'h0f, 8'h03);
        wr(8'h10, 8'h05);
        wr(8'h3c, 8'h01);
        host.set_power(8'h20, ok);
        ok_or_stop(ok);
        wr(8'h14, 8'h12);
        chk("no restart", 32'h0, {31'h0, pend});
        host.restart(ok);
        ok_or_stop(ok);
        chk("range held", 32'h3, {24'h0, rng});
        for (n = 0; n < RSTC + 10 && pend === 1'b1; n++) @(posedge clk_i);
        chk("restart delay", 32'h1, {31'h0, n >= RSTC - 6 && n <= RSTC});
        ok_or_stop(pend === 1'b0);
        rdchk(8'h0f, 8'h00);
        rdchk(8'h10, 8'h80);
        chk("filter", 32'h80, {24'h0, flt});
        chk("self test", 32'h0, {24'h0, stst});
        rdchk(8'h11, 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_rates();
        t_queue();
        t_power();
        t_restart();
        give_verdict();
    end
endmodule
